/* File: pfds_consts.svh */
/*
  register offsets, field positions, reset values and function codes
  for the pin function and drive select block.
  assumes: included by the design module and the bench by bare name.
*/
`ifndef PFDS_CONSTS_SVH
`define PFDS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte index on the plain register port)
// ----------------------------------------------------------------
`define PFDS_OFF_DRV_CD    4'h0
`define PFDS_OFF_DRV_E     4'h1
`define PFDS_OFF_PA_LO     4'h2
`define PFDS_OFF_PA_HI     4'h3
`define PFDS_OFF_PB_LO     4'h4
`define PFDS_OFF_PB_HI     4'h5
`define PFDS_OFF_PC_LO     4'h6
`define PFDS_OFF_PC_HI     4'h7
`define PFDS_OFF_PD        4'h8
`define PFDS_OFF_IFS_TMR   4'h9
`define PFDS_OFF_IFS_SER   4'hA
`define PFDS_OFF_DIR_A     4'hB

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define PFDS_RST_ZERO      8'h00
`define PFDS_RST_DIR       8'hFF
`define PFDS_MASK_DRV_E    8'h0F
`define PFDS_MASK_PD       8'h3F
`define PFDS_MASK_IFS_TMR  8'hE9
`define PFDS_MASK_IFS_SER  8'h70
`define PFDS_MASK_ALL      8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFDS_E_UP_LSB      2
`define PFDS_E_LO_LSB      0
`define PFDS_A3_LSB        6
`define PFDS_A2_LSB        4
`define PFDS_A1_LSB        2
`define PFDS_A0_LSB        0

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define PFDS_CODE_00       2'h0
`define PFDS_CODE_01       2'h1
`define PFDS_CODE_10       2'h2
`define PFDS_CODE_11       2'h3

`endif

/* File: pfds_pkg.sv */
/*
  types for the pin function and drive select block.
  assumes: the constants header sits in the same folder.
*/
package pfds_pkg;

  // ----------------------------------------------------------------
  // register port and pin carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pfds_bus_req_type;

  // per-pin peripheral drive: output value and its enable
  typedef struct packed {
    logic val;
    logic oe;
  } pfds_drive_type;

  // what each port A pin is routed to
  typedef enum logic [1:0] {
    PFDS_SEL_GPIO,
    PFDS_SEL_PERIPH_OUT,
    PFDS_SEL_OSC,
    PFDS_SEL_ANALOG
  } pfds_sel_type;

endpackage

/* File: pfds_top.sv */
/*
  pin function and drive select: register file, port A pin mux,
  source-current level outputs for ports C, D and E.
  assumes: one 25 MHz clock, synchronous active-high reset, a plain
  register port with read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "pfds_consts.svh"

// What this block does
// - each two-bit drive field gives levels 0 (00) to 3 (11).
// - port E drive bits 3..2 set the level of port E pins 6..4.
// - port E drive bits 1..0 set the level of port E pins 3..0.
// - port E drive bits 7..4 read zero and ignore writes.
// - pin A3 field: 00/10 io or capture, 01 timer1 out, 11 xtal out.
// - pin A2 field: 00/01/10 io or timer0 clock, 11 low crystal out.
// - pin A1 field: 00 io/irq/clock, 01 ovp ref, 10 lvd, 11 inv out.
// - pin A0 field: 00/01 io or capture, 10 timer0 out, 11 xtal in.
// - per-port output select and input source select registers exist.
// - direction bit 1 makes an input, 0 a push-pull output.

module pfds_top
  import pfds_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire pfds_bus_req_type bus_in,
  output logic [7:0]            rdata_out,
  input  wire logic [3:0]       gpio_out_in,
  input  wire logic [3:0]       pad_a_in,
  input  wire logic             timer0_output_in,
  input  wire logic             timer0_inverted_output_in,
  input  wire logic             timer1_output_in,
  output logic [3:0]            pad_a_out,
  output logic [3:0]            pad_a_oe_out,
  output logic [3:0]            pad_a_analog_out,
  output logic [3:0]            gpio_in_out,
  output logic                  external_interrupt_zero_out,
  output logic                  simple_timer_clock_input_out,
  output logic                  timer0_clock_input_out,
  output logic                  timer0_capture_input_out,
  output logic                  timer1_capture_input_out,
  output logic [1:0]            port_e_upper_group_level_out,
  output logic [1:0]            port_e_lower_group_level_out,
  output logic [7:0]            drive_level_ports_c_d_out,
  output logic [7:0]            port_b_c_d_select_out [5],
  output logic [7:0]            input_source_select_out [2]
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] drive_level_ports_c_d_reg;
  logic [7:0] drive_level_port_e_reg;
  logic [7:0] port_a_low_function_select_reg;
  logic [7:0] port_a_high_function_select_reg;
  logic [7:0] port_b_low_function_select_reg;
  logic [7:0] port_b_high_function_select_reg;
  logic [7:0] port_c_low_function_select_reg;
  logic [7:0] port_c_high_function_select_reg;
  logic [7:0] port_d_function_select_reg;
  logic [7:0] input_source_select_timers_reg;
  logic [7:0] input_source_select_serial_reg;
  logic [7:0] port_direction_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // write decode
  wire wr_drv_cd = bus_in.wr && bus_in.addr == `PFDS_OFF_DRV_CD;
  wire wr_drv_e  = bus_in.wr && bus_in.addr == `PFDS_OFF_DRV_E;
  wire wr_pa_lo  = bus_in.wr && bus_in.addr == `PFDS_OFF_PA_LO;
  wire wr_pa_hi  = bus_in.wr && bus_in.addr == `PFDS_OFF_PA_HI;
  wire wr_pb_lo  = bus_in.wr && bus_in.addr == `PFDS_OFF_PB_LO;
  wire wr_pb_hi  = bus_in.wr && bus_in.addr == `PFDS_OFF_PB_HI;
  wire wr_pc_lo  = bus_in.wr && bus_in.addr == `PFDS_OFF_PC_LO;
  wire wr_pc_hi  = bus_in.wr && bus_in.addr == `PFDS_OFF_PC_HI;
  wire wr_pd     = bus_in.wr && bus_in.addr == `PFDS_OFF_PD;
  wire wr_ifs_t  = bus_in.wr && bus_in.addr == `PFDS_OFF_IFS_TMR;
  wire wr_ifs_s  = bus_in.wr && bus_in.addr == `PFDS_OFF_IFS_SER;
  wire wr_dir    = bus_in.wr && bus_in.addr == `PFDS_OFF_DIR_A;

  // register updates, all fields start at zero except the direction register, which starts at all ones
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_level_ports_c_d_reg       <= `PFDS_RST_ZERO;
      drive_level_port_e_reg          <= `PFDS_RST_ZERO;
      port_a_low_function_select_reg  <= `PFDS_RST_ZERO;
      port_a_high_function_select_reg <= `PFDS_RST_ZERO;
      port_b_low_function_select_reg  <= `PFDS_RST_ZERO;
      port_b_high_function_select_reg <= `PFDS_RST_ZERO;
      port_c_low_function_select_reg  <= `PFDS_RST_ZERO;
      port_c_high_function_select_reg <= `PFDS_RST_ZERO;
      port_d_function_select_reg      <= `PFDS_RST_ZERO;
      input_source_select_timers_reg  <= `PFDS_RST_ZERO;
      input_source_select_serial_reg  <= `PFDS_RST_ZERO;
      port_direction_reg              <= `PFDS_RST_DIR;
    end else begin
      if (wr_drv_cd) drive_level_ports_c_d_reg <= bus_in.wdata;
      // upper nibble never stored
      if (wr_drv_e)
        drive_level_port_e_reg <= bus_in.wdata & `PFDS_MASK_DRV_E;
      if (wr_pa_lo) port_a_low_function_select_reg <= bus_in.wdata;
      if (wr_pa_hi) port_a_high_function_select_reg <= bus_in.wdata;
      if (wr_pb_lo) port_b_low_function_select_reg <= bus_in.wdata;
      if (wr_pb_hi) port_b_high_function_select_reg <= bus_in.wdata;
      if (wr_pc_lo) port_c_low_function_select_reg <= bus_in.wdata;
      if (wr_pc_hi) port_c_high_function_select_reg <= bus_in.wdata;
      if (wr_pd)
        port_d_function_select_reg <= bus_in.wdata & `PFDS_MASK_PD;
      // input source selects
      if (wr_ifs_t)
        input_source_select_timers_reg <=
          bus_in.wdata & `PFDS_MASK_IFS_TMR;
      if (wr_ifs_s)
        input_source_select_serial_reg <=
          bus_in.wdata & `PFDS_MASK_IFS_SER;
      if (wr_dir) port_direction_reg <= bus_in.wdata;
    end
  end

  // ----------------------------------------------------------------
  // read path, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = `PFDS_RST_ZERO;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `PFDS_OFF_DRV_CD:  rdata_next = drive_level_ports_c_d_reg;
        `PFDS_OFF_DRV_E:   rdata_next = drive_level_port_e_reg;
        `PFDS_OFF_PA_LO:   rdata_next = port_a_low_function_select_reg;
        `PFDS_OFF_PA_HI:   rdata_next = port_a_high_function_select_reg;
        `PFDS_OFF_PB_LO:   rdata_next = port_b_low_function_select_reg;
        `PFDS_OFF_PB_HI:   rdata_next = port_b_high_function_select_reg;
        `PFDS_OFF_PC_LO:   rdata_next = port_c_low_function_select_reg;
        `PFDS_OFF_PC_HI:   rdata_next = port_c_high_function_select_reg;
        `PFDS_OFF_PD:      rdata_next = port_d_function_select_reg;
        `PFDS_OFF_IFS_TMR: rdata_next = input_source_select_timers_reg;
        `PFDS_OFF_IFS_SER: rdata_next = input_source_select_serial_reg;
        `PFDS_OFF_DIR_A:   rdata_next = port_direction_reg;
        default:           rdata_next = `PFDS_RST_ZERO; // unmapped
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= `PFDS_RST_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // drive-strength level outputs
  // ----------------------------------------------------------------
  // two-bit codes pass straight to the pad level control
  assign port_e_upper_group_level_out =
    drive_level_port_e_reg[`PFDS_E_UP_LSB +: 2];
  assign port_e_lower_group_level_out =
    drive_level_port_e_reg[`PFDS_E_LO_LSB +: 2];
  assign drive_level_ports_c_d_out = drive_level_ports_c_d_reg;
  assign port_b_c_d_select_out[0]  = port_b_low_function_select_reg;
  assign port_b_c_d_select_out[1]  = port_b_high_function_select_reg;
  assign port_b_c_d_select_out[2]  = port_c_low_function_select_reg;
  assign port_b_c_d_select_out[3]  = port_c_high_function_select_reg;
  assign port_b_c_d_select_out[4]  = port_d_function_select_reg;
  assign input_source_select_out[0] = input_source_select_timers_reg;
  assign input_source_select_out[1] = input_source_select_serial_reg;

  // ----------------------------------------------------------------
  // port A function decode
  // ----------------------------------------------------------------
  wire [1:0] pin_a3_function_field =
    port_a_low_function_select_reg[`PFDS_A3_LSB +: 2];
  wire [1:0] pin_a2_function_field =
    port_a_low_function_select_reg[`PFDS_A2_LSB +: 2];
  wire [1:0] pin_a1_function_field =
    port_a_low_function_select_reg[`PFDS_A1_LSB +: 2];
  wire [1:0] pin_a0_function_field =
    port_a_low_function_select_reg[`PFDS_A0_LSB +: 2];

  pfds_sel_type   sel_a [4];
  pfds_drive_type per_a [4];

  // pin A3: 01 timer1 out, 11 crystal output, else io
  assign sel_a[3] =
    (pin_a3_function_field == `PFDS_CODE_01) ? PFDS_SEL_PERIPH_OUT :
    (pin_a3_function_field == `PFDS_CODE_11) ? PFDS_SEL_OSC :
                                               PFDS_SEL_GPIO;
  // pin A2: only 11 leaves io
  assign sel_a[2] =
    (pin_a2_function_field == `PFDS_CODE_11) ? PFDS_SEL_OSC :
                                               PFDS_SEL_GPIO;
  // pin A1: 01 and 10 are analogue inputs, 11 inverted out
  assign sel_a[1] =
    (pin_a1_function_field == `PFDS_CODE_00) ? PFDS_SEL_GPIO :
    (pin_a1_function_field == `PFDS_CODE_11) ? PFDS_SEL_PERIPH_OUT :
                                               PFDS_SEL_ANALOG;
  // pin A0: 10 timer0 out, 11 crystal input
  assign sel_a[0] =
    (pin_a0_function_field == `PFDS_CODE_10) ? PFDS_SEL_PERIPH_OUT :
    (pin_a0_function_field == `PFDS_CODE_11) ? PFDS_SEL_OSC :
                                               PFDS_SEL_GPIO;

  // peripheral output sources per pin
  assign per_a[3] = '{val: timer1_output_in, oe: 1'b1};
  assign per_a[2] = '{val: 1'b0, oe: 1'b0};
  assign per_a[1] = '{val: timer0_inverted_output_in, oe: 1'b1};
  assign per_a[0] = '{val: timer0_output_in, oe: 1'b1};

  // ----------------------------------------------------------------
  // per-pin mux: at most one source reaches each pad
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      wire is_gpio = sel_a[gi] == PFDS_SEL_GPIO;
      wire is_per  = sel_a[gi] == PFDS_SEL_PERIPH_OUT;
      // gpio drives only when direction is output
      assign pad_a_out[gi] = is_gpio ? gpio_out_in[gi] :
                             is_per  ? per_a[gi].val : 1'b0;
      assign pad_a_oe_out[gi] =
        is_gpio ? ~port_direction_reg[gi] :
        is_per  ? per_a[gi].oe : 1'b0;
      // oscillator and analogue pins hand the pad to analogue logic
      assign pad_a_analog_out[gi] = (sel_a[gi] == PFDS_SEL_OSC) ||
                                    (sel_a[gi] == PFDS_SEL_ANALOG);
      // digital read-back only while routed as io
      assign gpio_in_out[gi] = is_gpio & pad_a_in[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared digital inputs, valid only while the pin is an io input
  // ----------------------------------------------------------------
  wire [3:0] dig_in_ok = {
    sel_a[3] == PFDS_SEL_GPIO, sel_a[2] == PFDS_SEL_GPIO,
    sel_a[1] == PFDS_SEL_GPIO, sel_a[0] == PFDS_SEL_GPIO
  } & port_direction_reg[3:0];

  assign timer1_capture_input_out     = dig_in_ok[3] & pad_a_in[3];
  assign timer0_clock_input_out       = dig_in_ok[2] & pad_a_in[2];
  assign external_interrupt_zero_out  = dig_in_ok[1] & pad_a_in[1];
  assign simple_timer_clock_input_out = dig_in_ok[1] & pad_a_in[1];
  assign timer0_capture_input_out     = dig_in_ok[0] & pad_a_in[0];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  drv_e_upper_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    bus_in.rd && bus_in.addr == `PFDS_OFF_DRV_E |=> rdata_out[7:4] == 4'h0)
    else $error("port e drive upper bits not zero");

  drv_e_write_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_drv_e |=> port_e_upper_group_level_out == $past(bus_in.wdata[3:2])
      && port_e_lower_group_level_out == $past(bus_in.wdata[1:0]))
    else $error("port e level not taken from write");

  drv_cd_write_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_drv_cd |=> drive_level_ports_c_d_out == $past(bus_in.wdata))
    else $error("port c d level not taken from write");

  reset_clear_a: assert property (
    @(posedge clk_in)
    rst_in |=> drive_level_ports_c_d_out == 8'h00 && pad_a_analog_out == 4'h0
      && port_e_lower_group_level_out == 2'h0)
    else $error("fields not cleared by reset");

  a3_timer_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a3_function_field == 2'h1 |-> pad_a_oe_out[3]
      && pad_a_out[3] == timer1_output_in)
    else $error("pin a3 timer output not routed");

  a3_crystal_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a3_function_field == 2'h3 |-> !pad_a_oe_out[3] && pad_a_analog_out[3])
    else $error("pin a3 crystal select wrong");

  a2_crystal_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a2_function_field == 2'h3 |-> !pad_a_oe_out[2] && pad_a_analog_out[2])
    else $error("pin a2 crystal select wrong");

  a2_io_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a2_function_field != 2'h3 |-> !pad_a_analog_out[2]
      && pad_a_out[2] == gpio_out_in[2])
    else $error("pin a2 io select wrong");

  a1_analog_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a1_function_field inside {2'h1, 2'h2} |->
      pad_a_analog_out[1] && !pad_a_oe_out[1])
    else $error("pin a1 analogue select wrong");

  a1_inverted_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a1_function_field == 2'h3 |-> pad_a_oe_out[1]
      && pad_a_out[1] == timer0_inverted_output_in)
    else $error("pin a1 inverted output not routed");

  a0_timer_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a0_function_field == 2'h2 |-> pad_a_out[0] == timer0_output_in
      && pad_a_oe_out[0])
    else $error("pin a0 timer output not routed");

  a0_crystal_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_a0_function_field == 2'h3 |-> !pad_a_oe_out[0] && pad_a_analog_out[0])
    else $error("pin a0 crystal select wrong");

  gpio_dir_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    sel_a[0] == PFDS_SEL_GPIO |-> pad_a_oe_out[0] == !port_direction_reg[0])
    else $error("gpio enable does not follow direction");

  input_gate_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !dig_in_ok[1] |-> !external_interrupt_zero_out
      && !simple_timer_clock_input_out)
    else $error("shared input open while pin not an input");

  pad_alone_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (pad_a_analog_out & pad_a_oe_out) == 4'h0)
    else $error("pad driven while handed to analogue logic");

  read_once_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data outside read answer cycle");

  cov_a3_xtal_c: cover property (
    @(posedge clk_in) pin_a3_function_field == 2'h3);
  cov_a1_inv_c:  cover property (
    @(posedge clk_in) pin_a1_function_field == 2'h3);
  cov_e_max_c:   cover property (
    @(posedge clk_in) port_e_upper_group_level_out == 2'h3);
  cov_a0_tmr_c:  cover property (
    @(posedge clk_in) pad_a_oe_out[0] && pad_a_out[0]);
  cov_irq_in_c:  cover property (
    @(posedge clk_in) external_interrupt_zero_out);

endmodule

/* File: pfds_periph_model.sv */
/*
  far side of the pin function block: the timer peripherals that feed
  port A, and the pads with their outside drivers.
  assumes: one clock shared with the block; the bench enables the
  timers only after it has picked the pin function.
*/
`timescale 1ns/1ps

module pfds_periph_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tmr_en_in,
  input  wire logic [3:0] ext_level_in,
  input  wire logic [3:0] pad_a_out_in,
  input  wire logic [3:0] pad_a_oe_in,
  output logic            timer0_out,
  output logic            timer0_inv_out,
  output logic            timer1_out,
  output logic [3:0]      pad_level_out
);
  logic [1:0] tick_reg;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // outputs move only while enabled, idle low otherwise
  always_ff @(posedge clk_in) begin
    if (rst_in || !tmr_en_in) begin
      tick_reg <= 2'h0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
    end
  end

  assign timer0_out     = tmr_en_in & tick_reg[0];
  assign timer0_inv_out = tmr_en_in & ~tick_reg[0];
  assign timer1_out     = tmr_en_in & tick_reg[1];

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  // a pad follows the block where it drives, the outside elsewhere
  assign pad_level_out = (pad_a_oe_in & pad_a_out_in)
                       | (~pad_a_oe_in & ext_level_in);
endmodule

/* File: tb_top.sv */
/*
  self-checking bench for the pin function and drive select block.
  assumes: the package, the constants header and the far side model
  sit in the same folder.
*/
`timescale 1ns/1ps
`include "pfds_consts.svh"

module tb_top
  import pfds_pkg::*;
;
  logic             clk_in, rst_in, tmr_en, t0, t0b, t1;
  pfds_bus_req_type bus_reg;
  logic [7:0]       rdata, drv_cd;
  logic [3:0]       gpio_out, ext_level, pad_lvl, pad_o, pad_oe, pad_an;
  logic [3:0]       gpio_in;
  logic             external_interrupt_zero, simple_timer_clock_input, t0ck, t0cap, t1cap;
  logic [1:0]       e_up, e_lo;
  logic [7:0]       sel [5];
  logic [7:0]       ifs [2];
  int               n_errors, comparisons;

  pfds_top pfds_top_inst (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_reg),
    .rdata_out(rdata), .gpio_out_in(gpio_out), .pad_a_in(pad_lvl),
    .timer0_output_in(t0), .timer0_inverted_output_in(t0b),
    .timer1_output_in(t1), .pad_a_out(pad_o), .pad_a_oe_out(pad_oe),
    .pad_a_analog_out(pad_an), .gpio_in_out(gpio_in),
    .external_interrupt_zero_out(external_interrupt_zero),
    .simple_timer_clock_input_out(simple_timer_clock_input),
    .timer0_clock_input_out(t0ck), .timer0_capture_input_out(t0cap),
    .timer1_capture_input_out(t1cap),
    .port_e_upper_group_level_out(e_up),
    .port_e_lower_group_level_out(e_lo),
    .drive_level_ports_c_d_out(drv_cd), .port_b_c_d_select_out(sel),
    .input_source_select_out(ifs));

  pfds_periph_model pfds_periph_model_inst (
    .clk_in(clk_in), .rst_in(rst_in), .tmr_en_in(tmr_en),
    .ext_level_in(ext_level), .pad_a_out_in(pad_o),
    .pad_a_oe_in(pad_oe), .timer0_out(t0), .timer0_inv_out(t0b),
    .timer1_out(t1), .pad_level_out(pad_lvl));

  // ----------------------------------------------------------------
  // clock, shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_reg <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_reg <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_reg <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_reg <= '0;
    #1 d = rdata;
  endtask

  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // writable bits of each offset, zero where nothing is mapped
  function automatic logic [7:0] wmask(input int a);
    case (a)
      1:       return `PFDS_MASK_DRV_E;
      8:       return `PFDS_MASK_PD;
      9:       return `PFDS_MASK_IFS_TMR;
      10:      return `PFDS_MASK_IFS_SER;
      12, 13, 14, 15: return 8'h00;
      default: return `PFDS_MASK_ALL;
    endcase
  endfunction

  // pin use per code: 0 io, 1 peripheral output, 2 oscillator/analogue
  function automatic int kind(input int p, input int c);
    case (p)
      3:       return (c == 1) ? 1 : ((c == 3) ? 2 : 0);
      2:       return (c == 3) ? 2 : 0;
      1:       return (c == 0) ? 0 : ((c == 3) ? 1 : 2);
      default: return (c == 2) ? 1 : ((c == 3) ? 2 : 0);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      chk("reset value", (a == 11) ? `PFDS_RST_DIR : 8'h00, d);
    end
  endtask

  task automatic t_regs;
    logic [7:0] d;
    for (int a = 0; a < 16; a++) begin
      wr(a[3:0], 8'hA5);
      rd(a[3:0], d);
      chk("readback a5", 8'hA5 & wmask(a), d);
      wr(a[3:0], 8'h5A);
      rd(a[3:0], d);
      chk("readback 5a", 8'h5A & wmask(a), d);
    end
    @(posedge clk_in);
    #1 chk("read data idle", 8'h00, rdata);
    chk("drive c d", 8'h5A, drv_cd);
    for (int i = 0; i < 5; i++) begin
      chk("output select", 8'h5A & wmask(i + 4), sel[i]);
    end
    chk("timer source", 8'h5A & `PFDS_MASK_IFS_TMR, ifs[0]);
    chk("serial source", 8'h5A & `PFDS_MASK_IFS_SER, ifs[1]);
  endtask

  task automatic t_drive_e;
    logic [7:0] d;
    for (int c = 0; c < 4; c++) begin
      wr(`PFDS_OFF_DRV_E, {4'hF, c[1:0], ~c[1:0]});
      rd(`PFDS_OFF_DRV_E, d);
      chk("drive e read", {4'h0, c[1:0], ~c[1:0]}, d);
      chk("upper group", {6'h00, c[1:0]}, {6'h00, e_up});
      chk("lower group", {6'h00, ~c[1:0]}, {6'h00, e_lo});
    end
  endtask

  task automatic t_pin_mux;
    int k;
    logic pv;
    wr(`PFDS_OFF_DIR_A, 8'h05);
    gpio_out <= 4'hA;
    ext_level <= 4'h3;
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        tmr_en <= 1'b0;
        wr(`PFDS_OFF_PA_LO, 8'(c << (2 * p)));
        tmr_en <= 1'b1;
        @(posedge clk_in);
        #1 k = kind(p, c);
        pv = (p == 3) ? t1 : ((p == 1) ? t0b : t0);
        chk("pad enable", {7'h00, (k == 1) || (k == 0 && p[0])},
            {7'h00, pad_oe[p]});
        chk("pad analogue", {7'h00, k == 2},
            {7'h00, pad_an[p]});
        if (k != 2) begin
          chk("pad value", {7'h00, (k == 1) ? pv : gpio_out[p]},
              {7'h00, pad_o[p]});
        end
        chk("read back", {7'h00, (k == 0) ? pad_lvl[p] : 1'b0},
            {7'h00, gpio_in[p]});
      end
    end
  endtask

  task automatic t_capture;
    tmr_en <= 1'b0;
    wr(`PFDS_OFF_PA_LO, 8'h00);
    wr(`PFDS_OFF_DIR_A, 8'hFF);
    ext_level <= 4'hF;
    @(posedge clk_in);
    #1 chk("inputs open", 8'h3F,
           {2'h0, external_interrupt_zero, simple_timer_clock_input, t0ck, t0cap, t1cap, gpio_in[1]});
    wr(`PFDS_OFF_DIR_A, 8'h00);
    #1 chk("inputs gated", 8'h00,
           {3'h0, external_interrupt_zero, simple_timer_clock_input, t0ck, t0cap, t1cap});
    wr(`PFDS_OFF_DIR_A, 8'hFF);
    wr(`PFDS_OFF_PA_LO, 8'h02);
    #1 chk("capture on output", 8'h00, {7'h00, t0cap});
    chk("other capture", 8'h01, {7'h00, t1cap});
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    bus_reg = '0;
    gpio_out = 4'h0;
    ext_level = 4'h0;
    tmr_en = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_regs();
    t_drive_e();
    t_pin_mux();
    t_capture();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end
endmodule
